/* rtl/pmsem_pkg.sv */
// Package: constants, types and structs for the PWM mode switch / edge mux block
// Functional notes
// R1 - Automatic switching changes configuration in hardware with no software step.
// R2 - Two switching levels give three sets: base, mid-load and high-load.
// R3 - With switching on, the duty command picks the governing configuration set.
// R4 - Four thresholds form two upper/lower pairs giving hysteresis.
// R5 - Base to mid above low-upper; back to base below low-lower.
// R6 - Mid to high above high-upper; back to mid below high-lower.
// R7 - Current above reference during A conduction ends the A pulse at once (the engine does this only with resonant set).
// R8 - Optional: B pulse width copies the truncated A width.
// R9 - At low resonant frequency the rectifier on-time is clamped to a fixed value.
// R10 - Blanking window goes high at blanking-A start, low at blanking-A end.
// R11 - Edge generator uses own and next engine A/B; engine 3 wraps to 0.
// R12 - Each generated edge picks one of eight sources by 3-bit code.
// R13 - Edge generator disabled means its outputs have no effect.
// R14 - Output A crossbar: own A, edge A, blank, own B, next A/B, blanks n+1..n+3.
// R15 - Output B crossbar: own B, edge B, blank, own A, next A/B, blanks n+1..n+3.
// R16 - Crossbar engine indices wrap modulo four.
// R17 - Crossbar selections come from the active configuration set.
// R18 - Software disables high resolution before the crossbar; grain is then 4 ns.
// R19 - With crossbar and edge generator off, outputs follow normal pulse logic.
// R20 - A set change takes effect only at a switching-period boundary.
// R21 - With switching off, the base set is always used.
package pmsem_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int unsigned PMSEM_ENG = 4;
   localparam int unsigned PMSEM_CW = 16;
   localparam int unsigned PMSEM_DW = 18;
   localparam int unsigned PMSEM_XW = 4;
   localparam int unsigned PMSEM_EW = 3;
   localparam int unsigned PMSEM_IW = 2;
   localparam logic [PMSEM_CW-1:0] PMSEM_CNT_ZERO = 16'h0000;
   localparam logic [PMSEM_CW-1:0] PMSEM_CNT_ONE = 16'h0001;
   localparam logic [PMSEM_IW-1:0] PMSEM_IDX_ONE = 2'h1;
   localparam logic [PMSEM_IW-1:0] PMSEM_IDX_TWO = 2'h2;
   localparam logic [PMSEM_IW-1:0] PMSEM_IDX_THREE = 2'h3;
   // ----------------------------------------
   // Crossbar codes
   // ----------------------------------------
   localparam logic [PMSEM_XW-1:0] PMSEM_X_OWN = 4'h0;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_EDGE = 4'h1;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_BLANK = 4'h2;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_CROSS = 4'h3;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_NXT_A = 4'h4;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_NXT_B = 4'h5;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_BLK1 = 4'h6;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_BLK2 = 4'h7;
   localparam logic [PMSEM_XW-1:0] PMSEM_X_BLK3 = 4'h8;
   // Edge fine grain while the crossbar runs
   localparam int unsigned PMSEM_XBAR_GRAIN_NS = 4;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      PMSEM_SET_BASE = 2'b00,
      PMSEM_SET_MID = 2'b01,
      PMSEM_SET_HIGH = 2'b11
   } pmsem_set_e;

   typedef struct packed {
      logic [PMSEM_CW-1:0] period;
      logic [PMSEM_CW-1:0] a_on;
      logic [PMSEM_CW-1:0] a_off;
      logic [PMSEM_CW-1:0] b_on;
      logic [PMSEM_CW-1:0] b_off;
      logic [PMSEM_XW-1:0] xsel_a;
      logic [PMSEM_XW-1:0] xsel_b;
   } pmsem_cfg_s;

   typedef struct packed {
      logic [PMSEM_DW-1:0] low_lower;
      logic [PMSEM_DW-1:0] low_upper;
      logic [PMSEM_DW-1:0] high_lower;
      logic [PMSEM_DW-1:0] high_upper;
   } pmsem_thr_s;

   typedef struct packed {
      logic enable;
      logic [PMSEM_EW-1:0] a_rise;
      logic [PMSEM_EW-1:0] a_fall;
      logic [PMSEM_EW-1:0] b_rise;
      logic [PMSEM_EW-1:0] b_fall;
   } pmsem_edge_s;

   typedef struct packed {
      logic a_rise;
      logic a_fall;
      logic b_rise;
      logic b_fall;
   } pmsem_edges_s;
endpackage

/* rtl/pmsem_mode_sel.sv */
// Hysteretic selection of the active configuration set from the duty command
`timescale 1ns/1ps
module pmsem_mode_sel
   import pmsem_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic auto_en,
   input wire logic [PMSEM_DW-1:0] duty_cmd,
   input wire pmsem_thr_s thr,
   input wire logic period_end,
   output pmsem_set_e set_active
);
   // ----------------------------------------
   // Target set
   // ----------------------------------------
   pmsem_set_e state_r;
   pmsem_set_e target;
   wire logic up_mid = duty_cmd > thr.low_upper; // [R5]
   wire logic dn_base = duty_cmd < thr.low_lower; // [R5]
   wire logic up_high = duty_cmd > thr.high_upper; // [R6]
   wire logic dn_mid = duty_cmd < thr.high_lower; // [R6]

   // Hysteresis: with switching on, the set moves only one step per period boundary
   always_comb begin
      target = state_r;
      case (state_r)
         PMSEM_SET_BASE: if (up_mid) target = PMSEM_SET_MID; // [R4] [R5]
         PMSEM_SET_MID: begin
            if (up_high) target = PMSEM_SET_HIGH; // [R6]
            else if (dn_base) target = PMSEM_SET_BASE; // [R5]
         end
         PMSEM_SET_HIGH: if (dn_mid) target = PMSEM_SET_MID; // [R6]
         default: target = PMSEM_SET_BASE;
      endcase
      if (!auto_en) target = PMSEM_SET_BASE; // [R21]
   end

   // Change only at period end so no pulse mixes sets
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) state_r <= PMSEM_SET_BASE;
      else if (period_end) state_r <= target; // [R1] [R3] [R20]
   end

   assign set_active = state_r;
endmodule // pmsem_mode_sel

/* rtl/pmsem_engine.sv */
// One pulse engine: counter, A/B pulses, blanking window, truncation, clamp
`timescale 1ns/1ps
module pmsem_engine
   import pmsem_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic run,
   input wire pmsem_cfg_s cfg,
   input wire logic [PMSEM_CW-1:0] blank_start,
   input wire logic [PMSEM_CW-1:0] blank_end,
   input wire logic resonant,
   input wire logic cur_trip,
   input wire logic b_match,
   input wire logic [PMSEM_CW-1:0] sr_period_lim,
   input wire logic [PMSEM_CW-1:0] sr_on_fixed,
   output logic pwm_a,
   output logic pwm_b,
   output logic blank_win,
   output logic period_end
);
   // ----------------------------------------
   // Period counter
   // ----------------------------------------
   logic [PMSEM_CW-1:0] cnt_r;
   logic a_r;
   logic b_r;
   logic blk_r;
   logic trunc_r;
   logic [PMSEM_CW-1:0] a_width_r;
   wire logic last = cnt_r >= cfg.period - PMSEM_CNT_ONE;
   wire logic [PMSEM_CW-1:0] cnt_nxt = last ? PMSEM_CNT_ZERO : cnt_r + PMSEM_CNT_ONE;
   // Truncation: comparator ends A at the clock edge after the cycle it trips
   wire logic a_cut = resonant && cur_trip && a_r; // [R7]
   wire logic a_nxt = (cnt_nxt >= cfg.a_on) && (cnt_nxt < cfg.a_off) && !(a_cut || (trunc_r && !last));
   // Long resonant period: rectifier on-time stops growing
   wire logic clamp = resonant && (cfg.period > sr_period_lim); // [R9]
   wire logic [PMSEM_CW-1:0] b_len_cfg = clamp ? sr_on_fixed : cfg.b_off - cfg.b_on; // [R9]
   wire logic [PMSEM_CW-1:0] b_len = (b_match && resonant) ? a_width_r : b_len_cfg; // [R8]
   wire logic b_nxt = (cnt_nxt >= cfg.b_on) && (cnt_nxt - cfg.b_on < b_len);
   wire logic blk_nxt = (cnt_nxt >= blank_start) && (cnt_nxt < blank_end); // [R10]

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_r <= PMSEM_CNT_ZERO;
         a_r <= 1'b0;
         b_r <= 1'b0;
         blk_r <= 1'b0;
         trunc_r <= 1'b0;
         a_width_r <= PMSEM_CNT_ZERO;
      end else if (!run) begin
         cnt_r <= PMSEM_CNT_ZERO;
         a_r <= 1'b0;
         b_r <= 1'b0;
         blk_r <= 1'b0;
         trunc_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         a_r <= a_nxt;
         b_r <= b_nxt;
         blk_r <= blk_nxt; // [R10]
         trunc_r <= last ? 1'b0 : (trunc_r | a_cut); // [R7]
         // Measured A width of this half, reused by B when matching
         if (a_cut) a_width_r <= cnt_r - cfg.a_on + PMSEM_CNT_ONE; // [R8]
         else if (last && !trunc_r) a_width_r <= cfg.a_off - cfg.a_on;
      end
   end

   assign pwm_a = a_r;
   assign pwm_b = b_r;
   assign blank_win = blk_r;
   assign period_end = run && last;
endmodule // pmsem_engine

/* rtl/pmsem_top.sv */
// Top: four engines, configuration-set switching, edge generators and output crossbar
`timescale 1ns/1ps
module pmsem_top
   import pmsem_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [PMSEM_ENG-1:0] run,
   input wire logic [PMSEM_ENG-1:0] auto_en,
   input wire logic [PMSEM_ENG-1:0][PMSEM_DW-1:0] duty_cmd,
   input wire pmsem_thr_s [PMSEM_ENG-1:0] thr,
   input wire pmsem_cfg_s [PMSEM_ENG-1:0] base_pwm_config,
   input wire pmsem_cfg_s [PMSEM_ENG-1:0] cfg_mid,
   input wire pmsem_cfg_s [PMSEM_ENG-1:0] cfg_high,
   input wire logic [PMSEM_ENG-1:0][PMSEM_CW-1:0] blank_start,
   input wire logic [PMSEM_ENG-1:0][PMSEM_CW-1:0] blank_end,
   input wire logic [PMSEM_ENG-1:0] resonant,
   input wire logic [PMSEM_ENG-1:0] cur_trip,
   input wire logic [PMSEM_ENG-1:0] b_match,
   input wire logic [PMSEM_ENG-1:0][PMSEM_CW-1:0] sr_period_lim,
   input wire logic [PMSEM_ENG-1:0][PMSEM_CW-1:0] sr_on_fixed,
   input wire pmsem_edge_s [PMSEM_ENG-1:0] edge_generator_config,
   input wire logic [PMSEM_ENG-1:0] xbar_en,
   output logic [PMSEM_ENG-1:0] pwm_out_a,
   output logic [PMSEM_ENG-1:0] pwm_out_b,
   output logic [PMSEM_ENG-1:0] blanking_window_signal,
   output logic [PMSEM_ENG-1:0][1:0] active_set
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [PMSEM_IW-1:0] wrap(input int unsigned n, input logic [PMSEM_IW-1:0] k);
      logic [PMSEM_IW-1:0] i;
      i = PMSEM_IW'(n);
      return i + k; // [R16]
   endfunction

   function automatic logic pick_edge(input logic [PMSEM_EW-1:0] c, input pmsem_edges_s o, input pmsem_edges_s x);
      logic [7:0] v;
      v = {x.b_fall, x.b_rise, x.a_fall, x.a_rise, o.b_fall, o.b_rise, o.a_fall, o.a_rise};
      return v[c]; // [R12]
   endfunction

   // ----------------------------------------
   // Engines and set selection
   // ----------------------------------------
   logic [PMSEM_ENG-1:0] a_raw;
   logic [PMSEM_ENG-1:0] b_raw;
   logic [PMSEM_ENG-1:0] blk;
   logic [PMSEM_ENG-1:0] pend;
   pmsem_set_e set_act [PMSEM_ENG];
   pmsem_cfg_s cfg_act [PMSEM_ENG];
   logic [PMSEM_ENG-1:0] a_prev_r;
   logic [PMSEM_ENG-1:0] b_prev_r;
   pmsem_edges_s edg [PMSEM_ENG];
   logic [PMSEM_ENG-1:0] ga_r;
   logic [PMSEM_ENG-1:0] gb_r;
   logic [PMSEM_ENG-1:0] oa_r;
   logic [PMSEM_ENG-1:0] ob_r;

   for (genvar n = 0; n < PMSEM_ENG; n++) begin : g_eng
      pmsem_mode_sel u_sel (
         .clk_sys(clk_sys),
         .rst(rst),
         .auto_en(auto_en[n]),
         .duty_cmd(duty_cmd[n]),
         .thr(thr[n]),
         .period_end(pend[n]),
         .set_active(set_act[n])
      );
      // Two duplicate sets beside the base one
      assign cfg_act[n] = (set_act[n] == PMSEM_SET_HIGH) ? cfg_high[n] :
                          (set_act[n] == PMSEM_SET_MID) ? cfg_mid[n] : base_pwm_config[n]; // [R2] [R3]
      assign active_set[n] = set_act[n];

      pmsem_engine u_eng (
         .clk_sys(clk_sys),
         .rst(rst),
         .run(run[n]),
         .cfg(cfg_act[n]),
         .blank_start(blank_start[n]),
         .blank_end(blank_end[n]),
         .resonant(resonant[n]),
         .cur_trip(cur_trip[n]),
         .b_match(b_match[n]),
         .sr_period_lim(sr_period_lim[n]),
         .sr_on_fixed(sr_on_fixed[n]),
         .pwm_a(a_raw[n]),
         .pwm_b(b_raw[n]),
         .blank_win(blk[n]),
         .period_end(pend[n])
      );

      // ----------------------------------------
      // Edge generator
      // ----------------------------------------
      assign edg[n] = '{a_rise: a_raw[n] & ~a_prev_r[n], a_fall: ~a_raw[n] & a_prev_r[n],
                        b_rise: b_raw[n] & ~b_prev_r[n], b_fall: ~b_raw[n] & b_prev_r[n]};
      wire logic [PMSEM_IW-1:0] nx = wrap(n, PMSEM_IDX_ONE); // [R11]
      wire logic [PMSEM_IW-1:0] n2 = wrap(n, PMSEM_IDX_TWO);
      wire logic [PMSEM_IW-1:0] n3 = wrap(n, PMSEM_IDX_THREE);
      wire pmsem_edge_s ec = edge_generator_config[n];
      wire logic sa = pick_edge(ec.a_rise, edg[n], edg[nx]); // [R11] [R12]
      wire logic ca = pick_edge(ec.a_fall, edg[n], edg[nx]);
      wire logic sb = pick_edge(ec.b_rise, edg[n], edg[nx]);
      wire logic cb = pick_edge(ec.b_fall, edg[n], edg[nx]);
      // Set wins over clear when both edges coincide
      wire logic ga_nxt = !ec.enable ? 1'b0 : (sa ? 1'b1 : (ca ? 1'b0 : ga_r[n])); // [R13]
      wire logic gb_nxt = !ec.enable ? 1'b0 : (sb ? 1'b1 : (cb ? 1'b0 : gb_r[n])); // [R13]

      // ----------------------------------------
      // Output crossbar
      // ----------------------------------------
      // Routing follows the active set; fine edge placement is off here
      wire logic [PMSEM_XW-1:0] xa = cfg_act[n].xsel_a; // [R17] [R18]
      wire logic [PMSEM_XW-1:0] xb = cfg_act[n].xsel_b; // [R17]
      wire logic [8:0] src_a = {blk[n3], blk[n2], blk[nx], b_raw[nx], a_raw[nx], b_raw[n], blk[n],
                                ga_r[n] & ec.enable, a_raw[n]}; // [R14] [R16]
      wire logic [8:0] src_b = {blk[n3], blk[n2], blk[nx], b_raw[nx], a_raw[nx], a_raw[n], blk[n],
                                gb_r[n] & ec.enable, b_raw[n]}; // [R15] [R16]
      // Unknown codes fall back to pass-through
      wire logic oa_nxt = !xbar_en[n] ? a_raw[n] : (xa > PMSEM_X_BLK3 ? a_raw[n] : src_a[xa]); // [R14] [R19]
      wire logic ob_nxt = !xbar_en[n] ? b_raw[n] : (xb > PMSEM_X_BLK3 ? b_raw[n] : src_b[xb]); // [R15] [R19]

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            a_prev_r[n] <= 1'b0;
            b_prev_r[n] <= 1'b0;
            ga_r[n] <= 1'b0;
            gb_r[n] <= 1'b0;
            oa_r[n] <= 1'b0;
            ob_r[n] <= 1'b0;
         end else begin
            a_prev_r[n] <= a_raw[n];
            b_prev_r[n] <= b_raw[n];
            ga_r[n] <= ga_nxt;
            gb_r[n] <= gb_nxt;
            oa_r[n] <= oa_nxt;
            ob_r[n] <= ob_nxt;
         end
      end
   end

   assign pwm_out_a = oa_r;
   assign pwm_out_b = ob_r;
   assign blanking_window_signal = blk;
endmodule // pmsem_top

/* sim/pmsem_monitor.sv */
// Checker: concurrent assertions on the top-level ports
`timescale 1ns/1ps
module pmsem_monitor
   import pmsem_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [PMSEM_ENG-1:0] auto_en,
   input wire logic [PMSEM_ENG-1:0][PMSEM_DW-1:0] duty_cmd,
   input wire pmsem_thr_s [PMSEM_ENG-1:0] thr,
   input wire pmsem_cfg_s [PMSEM_ENG-1:0] base_pwm_config,
   input wire pmsem_edge_s [PMSEM_ENG-1:0] edge_generator_config,
   input wire logic [PMSEM_ENG-1:0] resonant,
   input wire logic [PMSEM_ENG-1:0] cur_trip,
   input wire logic [PMSEM_ENG-1:0] xbar_en,
   input wire logic [PMSEM_ENG-1:0] pwm_out_a,
   input wire logic [PMSEM_ENG-1:0] blanking_window_signal,
   input wire logic [PMSEM_ENG-1:0][1:0] active_set
);
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Set selection
   // ----------------------------------------
   set_code_a: assert property (active_set[0] != 2'b10) else $error("active set code unused");
   step_limit_a: assert property ($past(active_set[0]) == 2'b00 |-> active_set[0] != 2'b11)
      else $error("set skipped a step");
   mid_entry_a: assert property (active_set[0] == 2'b01 && $past(active_set[0]) == 2'b00
      |-> $past(duty_cmd[0]) > $past(thr[0].low_upper)) else $error("mid entered below threshold");
   base_return_a: assert property (active_set[0] == 2'b00 && $past(active_set[0]) == 2'b01
      |-> $past(duty_cmd[0]) < $past(thr[0].low_lower) || !$past(auto_en[0])) else $error("left mid early");
   high_entry_a: assert property (active_set[0] == 2'b11 && $past(active_set[0]) == 2'b01
      |-> $past(duty_cmd[0]) > $past(thr[0].high_upper)) else $error("high entered below threshold");
   no_auto_a: assert property (!auto_en[0] && !$past(auto_en[0]) |-> active_set[0] <= $past(active_set[0]))
      else $error("set rose with switching off");
   // ----------------------------------------
   // Crossbar, edge generator, truncation
   // ----------------------------------------
   blank_route_a: assert property ($past(xbar_en[0]) && $past(active_set[0]) == 2'b00
      && $past(base_pwm_config[0].xsel_a) == PMSEM_X_BLANK |-> pwm_out_a[0] == $past(blanking_window_signal[0]))
      else $error("blank route wrong");
   wrap_route_a: assert property ($past(xbar_en[3]) && $past(active_set[3]) == 2'b00
      && $past(base_pwm_config[3].xsel_a) == PMSEM_X_BLK1 |-> pwm_out_a[3] == $past(blanking_window_signal[0]))
      else $error("wrapped blank route wrong");
   edge_off_a: assert property ($past(xbar_en[1]) && $past(active_set[1]) == 2'b00
      && $past(base_pwm_config[1].xsel_a) == PMSEM_X_EDGE && !$past(edge_generator_config[1].enable)
      |-> !pwm_out_a[1]) else $error("disabled edge output active");
   trip_cut_a: assert property (resonant[0] && !xbar_en[0] && cur_trip[0] |=> ##1 !pwm_out_a[0])
      else $error("A pulse not cut on trip");
endmodule // pmsem_monitor

/* sim/pmsem_stage_model.sv */
// Power stage stand-in: current comparator that trips partway through an A pulse
`timescale 1ns/1ps
module pmsem_stage_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic gate_a,
   input wire logic [7:0] trip_at,
   output logic cur_trip
);
   logic [7:0] on_cnt_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         on_cnt_r <= 8'h00;
      end else begin
         on_cnt_r <= gate_a ? on_cnt_r + 8'h01 : 8'h00;
      end
   end
   // Sense only while A conducts; zero threshold means no overload
   assign cur_trip = gate_a && trip_at != 8'h00 && on_cnt_r >= trip_at;
endmodule // pmsem_stage_model

/* sim/pmsem_tb.sv */
// Testbench: set switching, crossbar, edge generator and truncation on engine 0
`timescale 1ns/1ps
module tb;
   import pmsem_pkg::*;
   logic clk_sys, rst;
   logic [PMSEM_ENG-1:0] run, auto_en, resonant, b_match, xbar_en, pwm_out_a, pwm_out_b, blanking_window_signal;
   logic [PMSEM_ENG-1:0][PMSEM_DW-1:0] duty_cmd;
   pmsem_thr_s [PMSEM_ENG-1:0] thr;
   pmsem_cfg_s [PMSEM_ENG-1:0] base_pwm_config, cfg_mid, cfg_high;
   logic [PMSEM_ENG-1:0][PMSEM_CW-1:0] blank_start, blank_end, sr_period_lim, sr_on_fixed;
   pmsem_edge_s [PMSEM_ENG-1:0] edge_generator_config;
   logic [PMSEM_ENG-1:0][1:0] active_set;
   wire logic trip0;
   wire logic [PMSEM_ENG-1:0] cur_trip;
   logic [7:0] trip_at;
   int error_cnt, num_checks, ca, cb;
   // Counts over two periods of 8: A 4 wide, B 2 wide, blank of engine k is 1+k wide
   int exp_a[10] = '{8, 0, 2, 4, 8, 4, 4, 6, 8, 8};
   int exp_b[10] = '{4, 0, 2, 8, 8, 4, 4, 6, 8, 4};
   int eg[3][6] = '{'{0, 1, 2, 3, 8, 4}, '{0, 3, 6, 7, 12, 4}, '{4, 7, 4, 5, 12, 8}};
   assign cur_trip = {3'h0, trip0};
   pmsem_top dut (.clk_sys(clk_sys), .rst(rst), .run(run), .auto_en(auto_en), .duty_cmd(duty_cmd), .thr(thr),
      .base_pwm_config(base_pwm_config), .cfg_mid(cfg_mid), .cfg_high(cfg_high), .blank_start(blank_start),
      .blank_end(blank_end), .resonant(resonant), .cur_trip(cur_trip), .b_match(b_match),
      .sr_period_lim(sr_period_lim), .sr_on_fixed(sr_on_fixed), .edge_generator_config(edge_generator_config),
      .xbar_en(xbar_en), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
      .blanking_window_signal(blanking_window_signal), .active_set(active_set));
   pmsem_stage_model stage (.clk_sys(clk_sys), .rst(rst), .gate_a(pwm_out_a[0]), .trip_at(trip_at), .cur_trip(trip0));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // Settle, then count high cycles over exactly two periods
   task automatic meas();
      ca = 0;
      cb = 0;
      repeat (8) @(negedge clk_sys);
      repeat (16) begin
         @(negedge clk_sys);
         ca += (pwm_out_a[0] === 1'b1);
         cb += (pwm_out_b[0] === 1'b1);
      end
   endtask
   task automatic set_chk(input logic [PMSEM_DW-1:0] d, input logic en, input logic [1:0] exp);
      int n;
      @(negedge clk_sys);
      duty_cmd[0] = d;
      auto_en[0] = en;
      n = 0;
      while (active_set[0] !== exp && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      if (active_set[0] !== exp) begin
         chk("set_wait", 0, 1);
         end_sim();
      end
      // Blank is high only at count 1, so a boundary change sees it one cycle later
      if (n > 0) begin
         @(negedge clk_sys);
         chk("set_boundary", 1, {31'h0, blanking_window_signal[0]});
      end
      repeat (16) @(negedge clk_sys);
      chk("active_set", {30'h0, exp}, {30'h0, active_set[0]});
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      error_cnt = 0;
      num_checks = 0;
      rst = 1'b1;
      run = 4'hf;
      auto_en = 4'h0;
      resonant = 4'h0;
      b_match = 4'h0;
      xbar_en = 4'b1010;
      trip_at = 8'h00;
      duty_cmd = '0;
      for (int k = 0; k < 4; k++) begin
         thr[k] = '{18'h00064, 18'h000c8, 18'h0012c, 18'h00190};
         base_pwm_config[k] = '{16'h0008, 16'h0000, 16'h0004, 16'h0004, 16'h0006, 4'h0, 4'h0};
         blank_start[k] = 16'h0001;
         blank_end[k] = 16'(2 + k);
         sr_period_lim[k] = 16'hffff;
         sr_on_fixed[k] = 16'h0001;
         edge_generator_config[k] = '0;
      end
      base_pwm_config[1].xsel_a = PMSEM_X_EDGE;
      base_pwm_config[3].xsel_a = PMSEM_X_BLK1;
      cfg_mid = base_pwm_config;
      cfg_high = base_pwm_config;
      cfg_mid[0].xsel_a = PMSEM_X_BLANK;
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      meas();
      chk("direct_a", 8, ca);
      chk("direct_b", 4, cb);
      @(negedge clk_sys);
      xbar_en[0] = 1'b1;
      for (int c = 0; c < 10; c++) begin
         @(negedge clk_sys);
         base_pwm_config[0].xsel_a = c[3:0];
         base_pwm_config[0].xsel_b = c[3:0];
         meas();
         chk("xbar_a", exp_a[c], ca);
         chk("xbar_b", exp_b[c], cb);
      end
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_sys);
         base_pwm_config[0].xsel_a = PMSEM_X_EDGE;
         base_pwm_config[0].xsel_b = PMSEM_X_EDGE;
         edge_generator_config[0] = '{1'b1, 3'(eg[i][0]), 3'(eg[i][1]), 3'(eg[i][2]), 3'(eg[i][3])};
         meas();
         chk("edge_a", eg[i][4], ca);
         chk("edge_b", eg[i][5], cb);
      end
      @(negedge clk_sys);
      edge_generator_config[0] = '0;
      base_pwm_config[0].xsel_a = PMSEM_X_OWN;
      base_pwm_config[0].xsel_b = PMSEM_X_OWN;
      set_chk(18'h00096, 1'b1, 2'b00);
      set_chk(18'h000fa, 1'b1, 2'b01);
      meas();
      chk("mid_route", 2, ca);
      set_chk(18'h00096, 1'b1, 2'b01);
      set_chk(18'h001c2, 1'b1, 2'b11);
      meas();
      chk("high_route", 8, ca);
      set_chk(18'h0015e, 1'b1, 2'b11);
      set_chk(18'h000fa, 1'b1, 2'b01);
      set_chk(18'h00032, 1'b1, 2'b00);
      set_chk(18'h001c2, 1'b0, 2'b00);
      @(negedge clk_sys);
      xbar_en[0] = 1'b0;
      resonant[0] = 1'b1;
      b_match[0] = 1'b1;
      trip_at = 8'h01;
      meas();
      chk("trip_a", 6, ca);
      chk("match_b", 6, cb);
      @(negedge clk_sys);
      trip_at = 8'h00;
      b_match[0] = 1'b0;
      sr_period_lim[0] = 16'h0004;
      meas();
      chk("sr_clamp_b", 2, cb);
      end_sim();
   end
endmodule // tb
bind pmsem_top pmsem_monitor mon (.clk_sys(clk_sys), .rst(rst), .auto_en(auto_en), .duty_cmd(duty_cmd), .thr(thr),
   .base_pwm_config(base_pwm_config), .edge_generator_config(edge_generator_config), .resonant(resonant),
   .cur_trip(cur_trip), .xbar_en(xbar_en), .pwm_out_a(pwm_out_a),
   .blanking_window_signal(blanking_window_signal), .active_set(active_set));
